// *** rtl/spc_regs.sv ***
/*
  Serial port slave with the configuration, readback, update strobe,
  scratch pad and identity registers of the device.
  Assumes the serial clock is at most one eighth of core_clk_in and that
  chip select falls a few core cycles before the first serial edge.
*/
module spc_regs #(
  parameter logic [7:0] REV_ID = 8'h5a, // Arbitrary value
  parameter logic [15:0] FAMILY_ID = 16'h3c3c // Arbitrary value
)(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe_out,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic eeprom_en_in,
  input wire logic pinprog_en_in,
  input wire logic [spc_pkg::ADDR_W-1:0] save_addr_in,
  output logic [7:0] save_data_out,
  output logic save_keep_out,
  output logic four_wire_out,
  output logic lsb_first_out,
  output logic soft_reset_out,
  output logic download_start_out
);
  import spc_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [4:0] sync_q; // Synchronised pins
  logic cs_n_s; // Chip select, low active
  logic sclk_s; // Serial clock level
  logic sdio_s; // Serial data in
  logic eep_s; // Profile memory enable strap
  logic pin_s; // Pin program enable strap

  // Chip select idles high, so its stage resets high: no false frame after reset
  spc_sync #(.W(5), .INIT(5'h01)) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in({pinprog_en_in, eeprom_en_in, spi_sdio_in, spi_sclk_in, spi_cs_n_in}),
    .sync_out(sync_q)
  );

  assign cs_n_s = sync_q[0];
  assign sclk_s = sync_q[1];
  assign sdio_s = sync_q[2];
  assign eep_s = sync_q[3];
  assign pin_s = sync_q[4];

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic sclk_d_r; // Delayed serial clock
  logic cs_d_r; // Delayed chip select
  logic sclk_rise; // Sample edge
  logic sclk_fall; // Launch edge
  logic cs_end; // Chip select rising, end of transfer

  // Delay copies of the synchronised levels
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  assign cs_end = cs_n_s & ~cs_d_r;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] cfg_r; // Only bits 7:6 are stored
  logic rb_r; // Readback selects buffer
  logic upd_r; // Update strobe bit as seen by reads
  logic [15:0] scr_buf_r; // Scratch pad, pending copy
  logic [15:0] scr_act_r; // Scratch pad, applied copy
  logic [7:0] rev_r; // Visible revision
  logic [15:0] fid_r; // Visible family code
  logic lsb; // Bit and byte order

  assign lsb = cfg_r[CFG_LSB_BIT];

  // ----------------------------------------
  // Serial framing state
  // ----------------------------------------
  spc_state_type state_r; // Framing state
  logic [3:0] cnt_r; // Bit count within field
  logic [15:0] instr_r; // Instruction shifter
  logic rw_r; // High for a read
  logic [12:0] addr_r; // Current register address
  logic [7:0] wsr_r; // Write data shifter
  logic [7:0] rsr_r; // Read data byte

  logic [15:0] instr_nxt; // Instruction with current bit
  logic [7:0] byte_nxt; // Write byte with current bit
  logic [12:0] addr_nxt; // Address after one byte
  logic instr_done; // Last instruction bit sampled
  logic byte_done; // Last data bit sampled
  logic wr_pulse; // Complete write byte
  logic soft_rst_now; // Soft reset written
  logic upd_now; // Update strobe written

  assign instr_nxt = lsb ? {sdio_s, instr_r[15:1]} : {instr_r[14:0], sdio_s};
  assign byte_nxt = spc_shift8(wsr_r, sdio_s, lsb);
  assign addr_nxt = lsb ? 13'(addr_r + ADDR_ONE) : 13'(addr_r - ADDR_ONE);
  assign instr_done = sclk_rise && (state_r == SPC_INSTR) && (cnt_r == INSTR_LAST);
  assign byte_done = sclk_rise && (state_r == SPC_DATA) && (cnt_r == BYTE_LAST);
  assign wr_pulse = byte_done && !rw_r;
  assign soft_rst_now = wr_pulse && (addr_r == ADDR_CFG) && byte_nxt[CFG_RST_BIT];
  assign upd_now = wr_pulse && (addr_r == ADDR_UPD) && byte_nxt[UPD_BIT];

  // Read decode; reserved bits and unmapped addresses give zero
  function automatic logic [7:0] rd_mux(input logic [12:0] a);
    case (a)
      ADDR_CFG: rd_mux = cfg_r & CFG_MASK;
      ADDR_RB: rd_mux = {7'h00, rb_r};
      ADDR_UPD: rd_mux = {7'h00, upd_r};
      ADDR_SCR_LO: rd_mux = rb_r ? scr_buf_r[7:0] : scr_act_r[7:0];
      ADDR_SCR_HI: rd_mux = rb_r ? scr_buf_r[15:8] : scr_act_r[15:8];
      ADDR_REV: rd_mux = rev_r;
      ADDR_FID_LO: rd_mux = fid_r[7:0];
      ADDR_FID_HI: rd_mux = fid_r[15:8];
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Framing: instruction, then bytes until chip select rises
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= SPC_IDLE;
      cnt_r <= 4'h0;
      instr_r <= 16'h0000;
      rw_r <= 1'b0;
      addr_r <= 13'h0000;
      wsr_r <= 8'h00;
      rsr_r <= 8'h00;
    end else begin
      case (state_r)
        SPC_IDLE: begin
          // Start on chip select low
          if (!cs_n_s) begin
            state_r <= SPC_INSTR;
            cnt_r <= 4'h0;
          end
        end
        SPC_INSTR: begin
          if (cs_n_s) begin
            state_r <= SPC_IDLE;
          end else if (instr_done) begin
            state_r <= SPC_DATA;
            cnt_r <= 4'h0;
            rw_r <= instr_nxt[INSTR_RW_BIT];
            addr_r <= instr_nxt[12:0];
            rsr_r <= rd_mux(instr_nxt[12:0]);
          end else if (sclk_rise) begin
            instr_r <= instr_nxt;
            cnt_r <= 4'(cnt_r + 4'h1);
          end
        end
        SPC_DATA: begin
          if (cs_n_s) begin
            state_r <= SPC_IDLE;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            addr_r <= addr_nxt;
            rsr_r <= rd_mux(addr_nxt);
          end else if (sclk_rise) begin
            wsr_r <= byte_nxt;
            cnt_r <= 4'(cnt_r + 4'h1);
          end
        end
        default: state_r <= SPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Configuration and readback select; soft reset restores defaults
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_r <= CFG_RST;
      rb_r <= 1'b0;
    end else if (soft_rst_now) begin
      cfg_r <= CFG_RST;
      rb_r <= 1'b0;
    end else if (wr_pulse && addr_r == ADDR_CFG) begin
      cfg_r <= byte_nxt & CFG_MASK;
    end else if (wr_pulse && addr_r == ADDR_RB) begin
      rb_r <= byte_nxt[RB_BIT];
    end
  end

  // Update strobe bit; a fresh strobe wins over the end-of-transfer clear
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      upd_r <= 1'b0;
    end else if (soft_rst_now) begin
      upd_r <= 1'b0;
    end else if (upd_now) begin
      upd_r <= 1'b1;
    end else if (cs_end) begin
      upd_r <= 1'b0;
    end
  end

  // Scratch pad, pending copy; inert storage only
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scr_buf_r <= SCR_RST;
    end else if (soft_rst_now) begin
      scr_buf_r <= SCR_RST;
    end else if (wr_pulse && addr_r == ADDR_SCR_LO) begin
      scr_buf_r[7:0] <= byte_nxt;
    end else if (wr_pulse && addr_r == ADDR_SCR_HI) begin
      scr_buf_r[15:8] <= byte_nxt;
    end
  end

  // Applied copy moves on update or soft reset; visible identity values move only on update
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scr_act_r <= SCR_RST;
      rev_r <= REV_ID;
      fid_r <= FAMILY_ID;
    end else if (soft_rst_now) begin
      scr_act_r <= SCR_RST;
    end else if (upd_now) begin
      scr_act_r <= scr_buf_r;
      rev_r <= REV_ID;
      fid_r <= FAMILY_ID;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic drive; // A read byte is on the wire

  assign drive = (state_r == SPC_DATA) && rw_r && !cs_n_s;

  // Launch on the falling edge; pin choice follows the wire mode
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spi_sdio_out <= 1'b0;
      spi_sdo_out <= 1'b0;
      spi_sdio_oe_out <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end else begin
      if (sclk_fall && drive) begin
        spi_sdio_out <= spc_pick(rsr_r, cnt_r, lsb);
        spi_sdo_out <= spc_pick(rsr_r, cnt_r, lsb);
      end
      spi_sdo_oe_out <= drive && cfg_r[CFG_SDO_BIT];
      spi_sdio_oe_out <= drive && !cfg_r[CFG_SDO_BIT];
    end
  end

  // ----------------------------------------
  // Side outputs
  // ----------------------------------------
  // Mode flags, reset pulses and the profile save port
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      four_wire_out <= 1'b0;
      lsb_first_out <= 1'b0;
      soft_reset_out <= 1'b0;
      download_start_out <= 1'b0;
      save_data_out <= 8'h00;
      save_keep_out <= 1'b0;
    end else begin
      four_wire_out <= cfg_r[CFG_SDO_BIT];
      lsb_first_out <= lsb;
      soft_reset_out <= soft_rst_now;
      download_start_out <= soft_rst_now && (eep_s || pin_s);
      save_data_out <= rd_mux(save_addr_in);
      save_keep_out <= (save_addr_in != ADDR_CFG);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_wire_exclusive: assert property (
    !(spi_sdo_oe_out && spi_sdio_oe_out)) else $error("both data pins driven");
  a_pin_by_mode: assert property (
    drive ##1 drive |-> (spi_sdo_oe_out == $past(cfg_r[CFG_SDO_BIT])))
    else $error("wrong output pin for wire mode");
  a_out_order: assert property (
    sclk_fall && drive |=> spi_sdio_out == spc_pick($past(rsr_r), $past(cnt_r), $past(lsb)))
    else $error("read bit out of order");
  a_addr_inc: assert property (
    byte_done && lsb && !cs_n_s |=> addr_r == 13'($past(addr_r) + ADDR_ONE))
    else $error("address not incremented");
  a_addr_dec: assert property (
    byte_done && !lsb && !cs_n_s |=> addr_r == 13'($past(addr_r) - ADDR_ONE))
    else $error("address not decremented");
  a_soft_reset: assert property (
    soft_rst_now |=> soft_reset_out && cfg_r == CFG_RST && scr_buf_r == SCR_RST ##1 !soft_reset_out)
    else $error("soft reset not a single pulse with defaults");
  a_save_excl: assert property (
    ##1 ($past(save_addr_in) == ADDR_CFG) == !save_keep_out)
    else $error("config offered for save");
  a_read_buffer: assert property (
    instr_done && rb_r && instr_nxt[12:0] == ADDR_SCR_LO |=> rsr_r == $past(scr_buf_r[7:0]))
    else $error("buffered readback wrong");
  a_read_active: assert property (
    instr_done && !rb_r && instr_nxt[12:0] == ADDR_SCR_HI |=> rsr_r == $past(scr_act_r[15:8]))
    else $error("active readback wrong");
  a_update_copy: assert property (
    upd_now && !soft_rst_now |=> scr_act_r == $past(scr_buf_r))
    else $error("update did not copy buffer");
  a_ro_hold: assert property (
    !upd_now |=> $stable(rev_r) && $stable(fid_r)) else $error("read-only moved without update");
  a_upd_clear: assert property (
    cs_end && !upd_now |=> !upd_r ##1 !upd_r || upd_now)
    else $error("update bit did not clear");
  a_scr_inert: assert property (
    !wr_pulse && !soft_rst_now |=> $stable(scr_buf_r)) else $error("scratch pad changed");
  a_rsvd_zero: assert property (
    (cfg_r & ~CFG_MASK) == 8'h00) else $error("reserved config bits set");

  c_read_xfer: cover property (byte_done && rw_r);
  c_write_upd: cover property (upd_now ##[1:300] cs_end);
  c_soft_rst: cover property (soft_rst_now && (eep_s || pin_s));
  c_lsb_write: cover property (wr_pulse && lsb);

endmodule

// *** rtl/spc_pkg.sv ***
/*
  Constants, types and helpers for the serial port configuration bank.
  Assumes one core clock and a host that keeps the serial clock far below it.
*/
package spc_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_CFG = 13'h0000;
  localparam logic [12:0] ADDR_RB = 13'h0004;
  localparam logic [12:0] ADDR_UPD = 13'h0005;
  localparam logic [12:0] ADDR_SCR_LO = 13'h0006;
  localparam logic [12:0] ADDR_SCR_HI = 13'h0007;
  localparam logic [12:0] ADDR_REV = 13'h000a;
  localparam logic [12:0] ADDR_FID_LO = 13'h000c;
  localparam logic [12:0] ADDR_FID_HI = 13'h000d;
  localparam logic [12:0] ADDR_ONE = 13'h0001;

  // ----------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------
  localparam int CFG_SDO_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_RST_BIT = 5;
  localparam logic [7:0] CFG_MASK = 8'hc0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int RB_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam logic [15:0] SCR_RST = 16'h0000;

  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  localparam int INSTR_RW_BIT = 15;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;

  typedef enum logic [1:0] {SPC_IDLE, SPC_INSTR, SPC_DATA} spc_state_type;

  // Shift one serial bit into a byte, in either bit order
  function automatic logic [7:0] spc_shift8(input logic [7:0] sr, input logic b,
                                            input logic lsb);
    spc_shift8 = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  // Pick the bit of a byte that goes out at a given bit count
  function automatic logic spc_pick(input logic [7:0] sr, input logic [3:0] idx,
                                    input logic lsb);
    spc_pick = lsb ? sr[idx[2:0]] : sr[3'h7 - idx[2:0]];
  endfunction

endpackage

// *** rtl/spc_sync.sv ***
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes each bit is an independent level; no bus coherency is given.
*/
module spc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0 // Reset level per bit; match each pin's idle level
)(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------
  // Flops
  // ----------------------------------------
  logic [W-1:0] meta_r; // First stage, read only by the second

  // Two flops in a row; second stage is the only reader of the first
  // Reset to the idle level so no false edge shows after reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= pins_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** test/spc_host_model.sv ***
/*
  Serial host model that drives frames into the configuration bank.
  Assumes a 50 MHz core clock and a device that launches read data on sclk falls.
*/
module spc_host_model (
  input wire logic core_clk_in,
  input wire logic dev_sdio_in,
  input wire logic dev_sdio_oe_in,
  input wire logic dev_sdo_in,
  input wire logic dev_sdo_oe_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdio_out,
  output logic sdo_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic host_oe; // High while the host drives sdio
  logic host_bit; // Bit the host puts on sdio
  logic tog_r = 1'b0; // Filler for released lines; flips every bit, so a stale pin reads 55 or aa
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b0;
  end
  // Flip once per serial bit; a flip per core cycle would alias to a constant at the sample point
  always @(posedge sclk_out) begin
    tog_r <= ~tog_r;
  end
  // Resolve both pins from every party's enable
  assign sdio_out = dev_sdio_oe_in ? dev_sdio_in : (host_oe ? host_bit : tog_r);
  assign sdo_out = dev_sdo_oe_in ? dev_sdo_in : tog_r;

  // One sclk period, eight core cycles per half, well inside the sync limit
  task automatic bit_cycle(input logic b, input logic drv, input logic rel,
                           input logic four, output logic got);
    host_oe = drv;
    host_bit = b;
    repeat (8) @(posedge core_clk_in);
    #1;
    got = four ? sdo_out : sdio_out;
    sclk_out = 1'b1;
    // Hand the pin over three cycles after the last instruction rise: the device has
    // taken the bit through its synchroniser and turns its driver on a cycle later
    repeat (3) @(posedge core_clk_in);
    #1;
    if (rel) begin
      host_oe = 1'b0;
    end
    repeat (5) @(posedge core_clk_in);
    #1;
    sclk_out = 1'b0;
  endtask

  // Whole frame: instruction then n bytes; byte k sits at bits 8k+7:8k
  task automatic xfer(input logic lsb, input logic four, input logic [15:0] ins,
                      input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic got;
    int j;
    rd = '0;
    cs_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      bit_cycle(lsb ? ins[i] : ins[15-i], 1'b1, ins[15] && i == 15, four, got);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        j = 8 * k + (lsb ? i : 7 - i);
        bit_cycle(wd[j], !ins[15], 1'b0, four, got);
        rd[j] = got;
      end
    end
    repeat (8) @(posedge core_clk_in);
    #1;
    cs_n_out = 1'b1;
    host_oe = 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1;
  endtask
endmodule

// *** test/test_spc_regs.sv ***
/*
  Self-checking bench for the serial configuration bank.
  Assumes the host model in its own file and the design's package constants.
*/
module test_spc_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import spc_pkg::*;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary value
  localparam logic [15:0] FAM = 16'h3c96; // Arbitrary value, bytes differ
  typedef struct {logic [12:0] a; logic [7:0] wd; logic [7:0] exp;} spc_row_type;
  logic core_clk_in, sys_rst_in, cs_n, sclk, sdio_w, sdo_w;
  logic dev_sdio, dev_sdio_oe, dev_sdo, dev_sdo_oe, eeprom_en, pinprog_en;
  logic save_keep, four_wire, lsb_first, soft_rst, dl_start, lsb_m, four_m;
  logic [ADDR_W-1:0] save_addr;
  logic [7:0] save_data;
  logic [31:0] rdv; // Read data of the last frame
  int failures, n_compared, cycles, n_sr, n_dl, oe_bad;
  // Write, then read back: value expected after the write
  spc_row_type rows [8] = '{'{ADDR_REV, 8'hff, REV}, '{ADDR_FID_LO, 8'hff, FAM[7:0]},
    '{ADDR_FID_HI, 8'h00, FAM[15:8]}, '{ADDR_ONE, 8'hff, 8'h00}, '{ADDR_RB, 8'hfe, 8'h00},
    '{ADDR_UPD, 8'hfe, 8'h00}, '{ADDR_CFG, 8'h1f, 8'h00}, '{ADDR_SCR_HI, 8'h5c, 8'h00}};

  spc_regs #(.REV_ID(REV), .FAMILY_ID(FAM)) spc_regs_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_sdio_in(sdio_w),
    .spi_sdio_out(dev_sdio), .spi_sdio_oe_out(dev_sdio_oe), .spi_sdo_out(dev_sdo),
    .spi_sdo_oe_out(dev_sdo_oe), .eeprom_en_in(eeprom_en), .pinprog_en_in(pinprog_en),
    .save_addr_in(save_addr), .save_data_out(save_data), .save_keep_out(save_keep),
    .four_wire_out(four_wire), .lsb_first_out(lsb_first), .soft_reset_out(soft_rst),
    .download_start_out(dl_start));
  spc_host_model spc_host_model_inst (.core_clk_in(core_clk_in), .dev_sdio_in(dev_sdio),
    .dev_sdio_oe_in(dev_sdio_oe), .dev_sdo_in(dev_sdo), .dev_sdo_oe_in(dev_sdo_oe),
    .cs_n_out(cs_n), .sclk_out(sclk), .sdio_out(sdio_w), .sdo_out(sdo_w));

  initial core_clk_in = 1'b0;
  always #10 core_clk_in = ~core_clk_in;
  // Pulse counters, sdio watch in 4-wire mode, and the hang limit
  always @(posedge core_clk_in) begin
    cycles++;
    if (soft_rst === 1'b1) n_sr++;
    if (dl_start === 1'b1) n_dl++;
    if (four_m && dev_sdio_oe !== 1'b0) oe_bad++;
    if (cycles == 60000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spc_host_model_inst.xfer(lsb_m, four_m, {3'b000, a}, 1, {24'h0, d}, rdv);
  endtask
  task automatic rd(input logic [12:0] a, input int n);
    spc_host_model_inst.xfer(lsb_m, four_m, {3'b100, a}, n, 32'h0, rdv);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    {sys_rst_in, eeprom_en, pinprog_en, lsb_m, four_m} = 5'b10000;
    save_addr = ADDR_CFG;
    {failures, n_compared, cycles, n_sr, n_dl, oe_bad} = '0;
    repeat (4) @(posedge core_clk_in);
    #1;
    sys_rst_in = 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1;
    check("four_wire reset", four_wire, 1'b0);
    check("lsb_first reset", lsb_first, 1'b0);
    check("save_keep cfg", save_keep, 1'b0);
    save_addr = ADDR_SCR_LO;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("save_keep scratch", save_keep, 1'b1);
    check("save_data scratch", save_data, SCR_RST);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, 1);
      check("row read", rdv[7:0], rows[i].exp);
      $display("test row %0d done", i);
    end
    // Two-byte MSB-first write steps down from the high byte
    spc_host_model_inst.xfer(1'b0, 1'b0, {3'b000, ADDR_SCR_HI}, 2, 32'h1122, rdv);
    rd(ADDR_SCR_HI, 2);
    check("scratch active", rdv[15:0], 16'h0000);
    wr(ADDR_RB, 8'h01);
    rd(ADDR_SCR_HI, 2);
    check("scratch buffer", rdv[15:0], 16'h1122);
    wr(ADDR_RB, 8'h00);
    wr(ADDR_UPD, 8'h01);
    rd(ADDR_UPD, 1);
    check("update clears", rdv[7:0], 8'h00);
    rd(ADDR_SCR_HI, 2);
    check("scratch applied", rdv[15:0], 16'h1122);
    rd(ADDR_FID_HI, 2);
    check("family msb order", rdv[15:0], {FAM[7:0], FAM[15:8]});
    $display("test buffer done");
    wr(ADDR_CFG, 8'h40);
    lsb_m = 1'b1;
    check("lsb_first set", lsb_first, 1'b1);
    spc_host_model_inst.xfer(1'b1, 1'b0, {3'b000, ADDR_SCR_LO}, 2, 32'h4433, rdv);
    wr(ADDR_RB, 8'h01);
    rd(ADDR_SCR_LO, 2);
    check("lsb scratch", rdv[15:0], 16'h4433);
    wr(ADDR_CFG, 8'hc0);
    four_m = 1'b1;
    check("four_wire set", four_wire, 1'b1);
    rd(ADDR_FID_LO, 2);
    check("family on sdo", rdv[15:0], FAM);
    check("sdio quiet", oe_bad, 0);
    $display("test order and wires done");
    // Soft reset with each strap and with none
    for (int s = 0; s < 3; s++) begin
      eeprom_en = (s == 0);
      pinprog_en = (s == 1);
      wr(ADDR_CFG, 8'h20);
      {lsb_m, four_m} = 2'b00;
      check("reset pulses", n_sr, s + 1);
      check("download pulses", n_dl, (s < 2) ? s + 1 : 2);
      check("cfg defaults", {four_wire, lsb_first}, 2'b00);
    end
    rd(ADDR_SCR_HI, 2);
    check("scratch after reset", rdv[15:0], 16'h0000);
    rd(ADDR_RB, 1);
    check("readback after reset", rdv[7:0], 8'h00);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
